// >>> verilog/mcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_regs
    import mcr_pkg::*;
#(
    parameter int unsigned OC_RECOVER_CYC    = OC_RECOVER_S * CLK_HZ,
    parameter int unsigned RESTART_SHORT_CYC = RESTART_SHORT_S * CLK_HZ,
    parameter int unsigned RESTART_LONG_CYC  = RESTART_LONG_S * CLK_HZ
) (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic [7:0]         regAddr,
    input  wire logic [15:0]        regWrData,
    input  wire logic               regWrEn,
    input  wire logic               regRdEn,
    output var  logic [15:0]        regRdData,
    output var  logic               regRdValid,
    input  wire logic [8:0]         spdPinDemand,
    input  wire mcr_pkg::mcr_meas_s meas,
    input  wire logic               overcurrentSense,
    input  wire logic               currentOverLimit,
    input  wire logic               motorRestart,
    input  wire logic               lockFault,
    output var  mcr_pkg::mcr_cfg_s  cfg,
    output var  logic [8:0]         demandApplied,
    output var  logic               currentLimitActive,
    output var  logic               overcurrentShutdown,
    output var  logic               restartRequest,
    output var  logic               restartsExhausted
);
    import mcr_pkg::*;

    localparam logic [TIMER_W-1:0] OC_RECOVER_T    = TIMER_W'(OC_RECOVER_CYC);
    localparam logic [TIMER_W-1:0] RESTART_SHORT_T = TIMER_W'(RESTART_SHORT_CYC);
    localparam logic [TIMER_W-1:0] RESTART_LONG_T  = TIMER_W'(RESTART_LONG_CYC);
    localparam logic [3:0]         OC_FILT_LAST    = 4'(OC_FILTER_CYC - 1);

    logic [15:0] words [NUM_CFG];

    // only configuration offsets decode a write; readback words have no storage
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
        mcr_cfg_word #(
            .MATCH     (CFG_OFS[i]),
            .RESET_VAL (CFG_RESET)
        ) u_word (
            .clk    (clk),
            .arst_n (arst_n),
            .addr   (regAddr),
            .wrData (regWrData),
            .wrEn   (regWrEn),
            .word   (words[i])
        );
    end

    // field decode: live from the stored words, registered once more
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= '0;
        end else begin
            cfg.detectCurrentThreshold <= words[W_DETECT][F_DETECT_LO +: 6];
            cfg.nudgeAmplitude         <= words[W_NUDGE][F_NUDGE_LO +: 3];
            cfg.observerPropGain       <= words[W_OBS_P][7:0];
            cfg.observerIntegralGain   <= words[W_OBS_I][7:0];
            cfg.senseResistor          <= words[W_SENSE][F_SENSE_LO +: 8];
            cfg.currentLimitEn         <= words[W_PROT][F_CUR_LIMIT_EN];
            cfg.tuneWindowOpen         <= words[W_OBS_P][F_TUNE_WINDOW];
            cfg.delayedStart           <= words[W_OBS_I][F_DELAY_START];
            cfg.firstCycleSpeed        <= words[W_OC_ST][F_FIRST_SPD_LO +: 2];
            cfg.deadTimeCycles         <= 5'((32'(words[W_LOCK_DT][F_DEADTIME_LO +: 4]) + 1)
                                             * DEADTIME_STEP_CYC);
            cfg.standbyAllowed         <= !words[W_NUDGE][F_STANDBY_DIS];
            cfg.fullBrake              <= words[W_RESTART][F_FULL_BRAKE];
            cfg.safeBrakeMult          <= 4'h1 << words[W_LOCK_DT][F_SAFE_BRAKE_LO +: 2];
            cfg.lockDetectEn           <= words[W_LOCK_DT][F_LOCK_ANGLE_LO +: 2] != 2'h0;
            cfg.lockAngleDeg           <= LOCK_DEG[words[W_LOCK_DT][F_LOCK_ANGLE_LO +: 2]];
        end
    end

    // speed demand selection, passed through unscaled so 0..511 stays linear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            demandApplied <= 9'h000;
        end else if (words[W_SPEED][F_DEMAND_SRC]) begin
            demandApplied <= words[W_SPEED][8:0];
        end else begin
            demandApplied <= spdPinDemand;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            currentLimitActive <= 1'b0;
        end else begin
            currentLimitActive <= words[W_PROT][F_CUR_LIMIT_EN] && currentOverLimit;
        end
    end

    // register reads: one cycle latency, unmapped offsets read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData  <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= 16'h0000;
                for (int i = 0; i < NUM_CFG; i++) begin
                    if (regAddr == CFG_OFS[i]) begin
                        regRdData <= words[i];
                    end
                end
                unique case (regAddr)
                    OFS_MEASURED_SPEED:   regRdData <= meas.speed;
                    OFS_MEASURED_BUS_CUR: regRdData <= meas.busCurrent;
                    OFS_MEASURED_TORQUE:  regRdData <= meas.torqueCurrent;
                    OFS_MEASURED_SUPPLY:  regRdData <= meas.supply;
                    OFS_MEASURED_TEMP:    regRdData <= meas.temperature;
                    OFS_APPLIED_DEMAND:   regRdData <= {7'h00, demandApplied};
                    OFS_APPLIED_COMMAND:  regRdData <= {7'h00, meas.controlCommand};
                    default: ;
                endcase
            end
        end
    end

    // overcurrent filter: sense must persist the whole window for code 100
    logic [2:0] ocSel;
    logic [3:0] ocRun_q;
    logic       ocTrip;
    assign ocSel = words[W_OC_ST][F_OC_FILTER_LO +: 3];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ocRun_q <= 4'h0;
        end else if (!overcurrentSense) begin
            ocRun_q <= 4'h0;
        end else if (ocRun_q != OC_FILT_LAST) begin
            ocRun_q <= ocRun_q + 4'h1;
        end
    end

    // codes other than 100 and 111 trip on the first sensed cycle
    always_comb begin
        ocTrip = 1'b0;
        if (overcurrentSense && ocSel != OC_DISABLED) begin
            ocTrip = (ocSel != OC_FILTER_480NS) || (ocRun_q == OC_FILT_LAST);
        end
    end

    logic [TIMER_W-1:0] ocTimer_q;
    logic               ocRecover;
    assign ocRecover = words[W_OC_ST][F_OC_RECOVERY];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ocTimer_q <= '0;
        end else if (ocTrip || !overcurrentShutdown || !ocRecover) begin
            ocTimer_q <= '0;
        end else if (ocTimer_q != OC_RECOVER_T - 1'b1) begin
            ocTimer_q <= ocTimer_q + 1'b1;
        end
    end

    // a fresh trip wins over any clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overcurrentShutdown <= 1'b0;
        end else if (ocTrip) begin
            overcurrentShutdown <= 1'b1;
        end else if (!ocRecover && motorRestart) begin
            overcurrentShutdown <= 1'b0;
        end else if (ocRecover && ocTimer_q == OC_RECOVER_T - 1'b1) begin
            overcurrentShutdown <= 1'b0;
        end
    end

    // lock fault retry: wait, then request a restart, up to the attempt limit
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_DONE} mcr_restart_e;
    mcr_restart_e       rsState_q;
    logic [TIMER_W-1:0] rsTimer_q;
    logic [TIMER_W-1:0] rsWaitLast;
    logic [3:0]         rsLimit;
    logic [3:0]         rsCount_q;
    assign rsWaitLast = (words[W_RESTART][F_LOCK_WAIT] ? RESTART_LONG_T : RESTART_SHORT_T)
                        - 1'b1;
    assign rsLimit    = RESTART_LIMIT[words[W_RESTART][F_RESTART_LO +: 2]];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsState_q      <= RS_IDLE;
            rsTimer_q      <= '0;
            rsCount_q      <= 4'h0;
            restartRequest <= 1'b0;
        end else begin
            restartRequest <= 1'b0;
            unique case (rsState_q)
                RS_IDLE: begin
                    rsTimer_q <= '0;
                    if (lockFault) begin
                        // limit code 0 retries forever; the count saturates
                        if (rsLimit == 4'h0 || rsCount_q < rsLimit) begin
                            rsState_q <= RS_WAIT;
                        end else begin
                            rsState_q <= RS_DONE;
                        end
                    end
                end
                RS_WAIT: begin
                    if (rsTimer_q >= rsWaitLast) begin
                        rsState_q      <= RS_IDLE;
                        restartRequest <= 1'b1;
                        if (rsCount_q != 4'hf) begin
                            rsCount_q <= rsCount_q + 4'h1;
                        end
                    end else begin
                        rsTimer_q <= rsTimer_q + 1'b1;
                    end
                end
                RS_DONE: begin
                    // only a fresh start command rearms the retries
                    if (motorRestart) begin
                        rsState_q <= RS_IDLE;
                        rsCount_q <= 4'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            restartsExhausted <= 1'b0;
        end else begin
            restartsExhausted <= (rsState_q == RS_DONE) && !motorRestart;
        end
    end

    // separate count for the filter check, so a broken filter counter cannot hide
    logic [3:0] chkOcHeld_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chkOcHeld_q <= 4'h0;
        end else if (!overcurrentSense || ocSel != OC_FILTER_480NS) begin
            chkOcHeld_q <= 4'h0;
        end else if (chkOcHeld_q != 4'hf) begin
            chkOcHeld_q <= chkOcHeld_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_deadtime_write;
        regWrEn && regAddr == OFS_LOCK_SOFT_DEADTIME;
    endsequence

    sequence s_oc_held;
        overcurrentSense && ocSel == OC_FILTER_480NS && chkOcHeld_q >= OC_FILT_LAST;
    endsequence

    chk_rd_latency: assert property (regRdEn |=> regRdValid)
        else $error("read answer missing one cycle after request");

    chk_deadtime_apply: assert property (s_deadtime_write |-> ##2
        cfg.deadTimeCycles == 5'($past(regWrData[11:8], 2)) + 5'd1)
        else $error("dead time field not applied two cycles after write");

    chk_limit_gate: assert property (currentLimitActive |->
        $past(currentOverLimit) && $past(words[W_PROT][F_CUR_LIMIT_EN]))
        else $error("current limit active while disabled");

    chk_ocp_disabled: assert property ($rose(overcurrentShutdown) |->
        $past(ocSel) != OC_DISABLED)
        else $error("overcurrent shutdown while protection disabled");

    // twelve sensed cycles in a row at code 100 must latch the shutdown
    chk_ocp_filter: assert property (s_oc_held |=> overcurrentShutdown)
        else $error("sustained overcurrent not latched after filter");

    chk_ocp_short: assert property ((ocSel == OC_FILTER_480NS &&
        !overcurrentShutdown && !overcurrentSense) ##1
        (overcurrentSense && ocSel == OC_FILTER_480NS) [*3] |=> !overcurrentShutdown)
        else $error("short overcurrent pulse passed the filter");

    chk_demand_src: assert property (words[W_SPEED][F_DEMAND_SRC] |=>
        demandApplied == $past(words[W_SPEED][8:0]))
        else $error("register demand not applied");

    chk_rb_temp: assert property (regRdEn && regAddr == OFS_MEASURED_TEMP |=>
        regRdData == $past(meas.temperature))
        else $error("temperature readback mismatch");

    chk_exhaust_quiet: assert property (restartsExhausted |-> !restartRequest)
        else $error("restart requested after attempts exhausted");

    // decode lags the stored word by one edge; skip the edge that leaves reset
    chk_brake_mult: assert property ($past(arst_n) |->
        cfg.safeBrakeMult == 4'h1 << $past(words[W_LOCK_DT][F_SAFE_BRAKE_LO +: 2]))
        else $error("safe brake multiplier wrong");

    chk_standby_map: assert property ($past(arst_n) |->
        cfg.standbyAllowed == !$past(words[W_NUDGE][F_STANDBY_DIS]))
        else $error("standby permission does not follow its control bit");

    chk_oc_sticky: assert property (overcurrentShutdown && !ocRecover && !motorRestart |=>
        overcurrentShutdown)
        else $error("overcurrent shutdown cleared without restart");

    chk_oc_restart_clr: assert property (!overcurrentSense && !ocRecover && motorRestart |=>
        !overcurrentShutdown)
        else $error("restart did not clear overcurrent shutdown");

    chk_restart_src: assert property (restartRequest |-> $past(rsState_q) == RS_WAIT)
        else $error("restart requested without a completed wait");

endmodule
`default_nettype wire

// >>> verilog/mcr_pkg.sv
package mcr_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // configuration word offsets
    localparam logic [7:0] OFS_PROTECTION_OPTION  = 8'h0b;
    localparam logic [7:0] OFS_OBSERVER_P_INDUCT  = 8'h0c;
    localparam logic [7:0] OFS_OBSERVER_I_DELAY   = 8'h0d;
    localparam logic [7:0] OFS_LOCK_SOFT_DEADTIME = 8'h0f;
    localparam logic [7:0] OFS_OVERCURRENT_START  = 8'h10;
    localparam logic [7:0] OFS_SPEED_DEMAND       = 8'h11;
    localparam logic [7:0] OFS_DETECT_THRESHOLD   = 8'h12;
    localparam logic [7:0] OFS_SENSE_SCALE        = 8'h14;
    localparam logic [7:0] OFS_SLIGHT_MOVE_STBY   = 8'h15;
    localparam logic [7:0] OFS_RESTART_BRAKE      = 8'h16;

    // readback word offsets
    localparam logic [7:0] OFS_MEASURED_SPEED     = 8'h78;
    localparam logic [7:0] OFS_MEASURED_BUS_CUR   = 8'h79;
    localparam logic [7:0] OFS_MEASURED_TORQUE    = 8'h7a;
    localparam logic [7:0] OFS_MEASURED_SUPPLY    = 8'h7b;
    localparam logic [7:0] OFS_MEASURED_TEMP      = 8'h7c;
    localparam logic [7:0] OFS_APPLIED_DEMAND     = 8'h7d;
    localparam logic [7:0] OFS_APPLIED_COMMAND    = 8'h7e;

    localparam int NUM_CFG = 10;
    localparam logic [7:0] CFG_OFS [NUM_CFG] = '{
        OFS_PROTECTION_OPTION, OFS_OBSERVER_P_INDUCT, OFS_OBSERVER_I_DELAY,
        OFS_LOCK_SOFT_DEADTIME, OFS_OVERCURRENT_START, OFS_SPEED_DEMAND,
        OFS_DETECT_THRESHOLD, OFS_SENSE_SCALE, OFS_SLIGHT_MOVE_STBY,
        OFS_RESTART_BRAKE};
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // index of each word in the storage array
    localparam int W_PROT    = 0;
    localparam int W_OBS_P   = 1;
    localparam int W_OBS_I   = 2;
    localparam int W_LOCK_DT = 3;
    localparam int W_OC_ST   = 4;
    localparam int W_SPEED   = 5;
    localparam int W_DETECT  = 6;
    localparam int W_SENSE   = 7;
    localparam int W_NUDGE   = 8;
    localparam int W_RESTART = 9;

    // field positions
    localparam int F_CUR_LIMIT_EN  = 7;
    localparam int F_TUNE_WINDOW   = 15;
    localparam int F_DELAY_START   = 14;
    localparam int F_FIRST_SPD_LO  = 6;
    localparam int F_DEADTIME_LO   = 8;
    localparam int F_STANDBY_DIS   = 15;
    localparam int F_FULL_BRAKE    = 8;
    localparam int F_SAFE_BRAKE_LO = 14;
    localparam int F_OC_RECOVERY   = 3;
    localparam int F_OC_FILTER_LO  = 0;
    localparam int F_LOCK_ANGLE_LO = 2;
    localparam int F_RESTART_LO    = 6;
    localparam int F_LOCK_WAIT     = 11;
    localparam int F_DEMAND_SRC    = 9;
    localparam int F_DETECT_LO     = 8;
    localparam int F_NUDGE_LO      = 5;
    localparam int F_SENSE_LO      = 8;

    localparam logic [2:0] OC_FILTER_480NS = 3'h4;
    localparam logic [2:0] OC_DISABLED     = 3'h7;

    localparam logic [3:0] LOCK_DEG [4]      = '{4'h0, 4'h5, 4'h9, 4'hd};
    localparam logic [3:0] RESTART_LIMIT [4] = '{4'h0, 4'h3, 4'h5, 4'ha};

    // timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int CLK_HZ            = 25_000_000;
    localparam int OC_FILTER_NS      = 480;
    localparam int OC_FILTER_CYC     = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEADTIME_STEP_NS  = 40;
    localparam int DEADTIME_STEP_CYC = (DEADTIME_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_RECOVER_S      = 5;
    localparam int RESTART_SHORT_S   = 5;
    localparam int RESTART_LONG_S    = 10;
    localparam int TIMER_W           = 28;

    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] busCurrent;
        logic [15:0] torqueCurrent;
        logic [15:0] supply;
        logic [15:0] temperature;
        logic [8:0]  controlCommand;
    } mcr_meas_s;

    typedef struct packed {
        logic [5:0] detectCurrentThreshold;
        logic [2:0] nudgeAmplitude;
        logic [7:0] observerPropGain;
        logic [7:0] observerIntegralGain;
        logic [7:0] senseResistor;
        logic       currentLimitEn;
        logic       tuneWindowOpen;
        logic       delayedStart;
        logic [1:0] firstCycleSpeed;
        logic [4:0] deadTimeCycles;
        logic       standbyAllowed;
        logic       fullBrake;
        logic [3:0] safeBrakeMult;
        logic       lockDetectEn;
        logic [3:0] lockAngleDeg;
    } mcr_cfg_s;

endpackage

// >>> verilog/mcr_cfg_word.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_cfg_word #(
    parameter logic [7:0]  MATCH     = 8'h00,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrEn,
    output var  logic [15:0] word
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word <= RESET_VAL;
        end else if (wrEn && addr == MATCH) begin
            word <= wrData;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/mcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model
    import mcr_pkg::*;
(
    input  wire logic        clk,
    output var  logic [7:0]  regAddr,
    output var  logic [15:0] regWrData,
    output var  logic        regWrEn,
    output var  logic        regRdEn,
    input  wire logic [15:0] regRdData,
    input  wire logic        regRdValid
);
    initial begin
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // idle lines carry inverted values so a stale word never looks valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(posedge clk);
        d = (regRdValid === 1'b1) ? regRdData : 16'hxxxx;
    endtask
    // register source selected, code limited to nine bits
    task automatic set_demand(input logic [8:0] code);
        wr(OFS_SPEED_DEMAND, {6'h00, 1'b1, code});
    endtask
endmodule
`default_nettype wire

// >>> testbench/mcr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_regs_test;
    import mcr_pkg::*;
    logic        clk;
    logic        arst_n;
    logic [7:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [15:0] regRdData;
    logic        regRdValid;
    logic [8:0]  spdPinDemand;
    mcr_meas_s   meas;
    logic        overcurrentSense;
    logic        currentOverLimit;
    logic        motorRestart;
    logic        lockFault;
    mcr_cfg_s    cfg;
    logic [8:0]  demandApplied;
    logic        currentLimitActive;
    logic        overcurrentShutdown;
    logic        restartRequest;
    logic        restartsExhausted;
    int          errCount = 0;
    int          cmpCount = 0;
    logic [15:0] rb [7] = '{16'h1234, 16'h0a5a, 16'hf00f, 16'h00fa, 16'h0080, 16'h01ff, 16'h01c3};

    mcr_regs #(.OC_RECOVER_CYC(20), .RESTART_SHORT_CYC(20), .RESTART_LONG_CYC(40)) i_dut (
        .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .spdPinDemand(spdPinDemand), .meas(meas), .overcurrentSense(overcurrentSense),
        .currentOverLimit(currentOverLimit), .motorRestart(motorRestart),
        .lockFault(lockFault), .cfg(cfg), .demandApplied(demandApplied),
        .currentLimitActive(currentLimitActive), .overcurrentShutdown(overcurrentShutdown),
        .restartRequest(restartRequest), .restartsExhausted(restartsExhausted));

    mcr_host_model i_host (
        .clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (errCount == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        i_host.rd(a, d);
        check(what, exp, d);
    endtask
    task automatic trip(input int n);
        @(posedge clk);
        overcurrentSense <= 1'b1;
        tick(n);
        overcurrentSense <= 1'b0;
        tick(2);
    endtask

    task automatic fault_pulse();
        @(posedge clk);
        lockFault <= 1'b1;
        @(posedge clk);
        lockFault <= 1'b0;
    endtask
    task automatic req_count(input int span, output int c);
        c = 0;
        repeat (span) begin
            @(posedge clk);
            if (restartRequest === 1'b1) c++;
        end
    endtask

    initial begin
        int n;
        int m;
        arst_n = 1'b0;
        spdPinDemand = 9'h1a5;
        meas = {16'h1234, 16'h0a5a, 16'hf00f, 16'h00fa, 16'h0080, 9'h1c3};
        overcurrentSense = 1'b0;
        currentOverLimit = 1'b1;
        motorRestart = 1'b0;
        lockFault = 1'b0;
        tick(16);
        arst_n <= 1'b1;
        tick(3);
        foreach (CFG_OFS[i]) rdchk(CFG_OFS[i], 16'h0000, "cfg reset");
        check("deadtime reset", 16'h0001, 16'(cfg.deadTimeCycles));
        check("brake mult reset", 16'h0001, 16'(cfg.safeBrakeMult));
        check("standby reset", 16'h0001, 16'(cfg.standbyAllowed));
        check("limit off", 16'h0000, 16'(currentLimitActive));
        check("pin demand", 16'h01a5, 16'(demandApplied));
        foreach (CFG_OFS[i]) i_host.wr(CFG_OFS[i], {CFG_OFS[i], ~CFG_OFS[i]});
        foreach (CFG_OFS[i]) rdchk(CFG_OFS[i], {CFG_OFS[i], ~CFG_OFS[i]}, "cfg word");
        i_host.wr(OFS_DETECT_THRESHOLD, 16'h3f00);
        i_host.wr(OFS_SLIGHT_MOVE_STBY, 16'h80a0);
        i_host.wr(OFS_OBSERVER_P_INDUCT, 16'h80a5);
        i_host.wr(OFS_OBSERVER_I_DELAY, 16'h405a);
        i_host.wr(OFS_SENSE_SCALE, 16'hc300);
        i_host.wr(OFS_OVERCURRENT_START, 16'h0084);
        i_host.wr(OFS_RESTART_BRAKE, 16'h0140);
        i_host.wr(OFS_PROTECTION_OPTION, 16'h0080);
        tick(2);
        check("detect thr", 16'h003f, 16'(cfg.detectCurrentThreshold));
        check("nudge", 16'h0005, 16'(cfg.nudgeAmplitude));
        check("standby", 16'h0000, 16'(cfg.standbyAllowed));
        check("prop gain", 16'h00a5, 16'(cfg.observerPropGain));
        check("tune window", 16'h0001, 16'(cfg.tuneWindowOpen));
        check("int gain", 16'h005a, 16'(cfg.observerIntegralGain));
        check("delayed start", 16'h0001, 16'(cfg.delayedStart));
        check("sense", 16'h00c3, 16'(cfg.senseResistor));
        check("first speed", 16'h0002, 16'(cfg.firstCycleSpeed));
        check("full brake", 16'h0001, 16'(cfg.fullBrake));
        check("limit en", 16'h0001, 16'(cfg.currentLimitEn));
        check("limit on", 16'h0001, 16'(currentLimitActive));
        for (int k = 0; k < 4; k++) begin
            i_host.wr(OFS_LOCK_SOFT_DEADTIME, {2'(k), 2'b00, 4'(k * 5), 4'h0, 2'(k), 2'b00});
            tick(2);
            check("deadtime", 16'(k * 5 + 1), 16'(cfg.deadTimeCycles));
            check("brake mult", 16'(1 << k), 16'(cfg.safeBrakeMult));
            check("lock angle", 16'(k == 0 ? 0 : 4 * k + 1), 16'(cfg.lockAngleDeg));
            check("lock en", 16'(k != 0), 16'(cfg.lockDetectEn));
        end
        i_host.set_demand(9'h1ff);
        tick(2);
        check("reg demand", 16'h01ff, 16'(demandApplied));
        for (int p = 0; p < 2; p++) begin
            for (int j = 0; j < 7; j++) begin
                if (p == 1) i_host.wr(8'h78 + 8'(j), 16'hffff);
                rdchk(8'h78 + 8'(j), rb[j], "readback");
            end
        end
        i_host.wr(8'h30, 16'hbeef);
        rdchk(8'h30, 16'h0000, "unmapped");
        // filter code with restart recovery: short burst must not trip
        trip(8);
        check("oc filtered", 16'h0000, 16'(overcurrentShutdown));
        trip(16);
        check("oc trip", 16'h0001, 16'(overcurrentShutdown));
        tick(40);
        check("oc held", 16'h0001, 16'(overcurrentShutdown));
        @(posedge clk);
        motorRestart <= 1'b1;
        @(posedge clk);
        motorRestart <= 1'b0;
        tick(2);
        check("oc restart clr", 16'h0000, 16'(overcurrentShutdown));
        i_host.wr(OFS_OVERCURRENT_START, 16'h000c);
        trip(16);
        check("oc trip timed", 16'h0001, 16'(overcurrentShutdown));
        tick(40);
        check("oc timed clr", 16'h0000, 16'(overcurrentShutdown));
        i_host.wr(OFS_OVERCURRENT_START, 16'h0007);
        trip(30);
        check("oc disabled", 16'h0000, 16'(overcurrentShutdown));
        // three attempts with the short wait, the fourth fault finds them used up
        n = 0;
        for (int f = 0; f < 4; f++) begin
            fault_pulse();
            req_count(40, m);
            n += m;
        end
        check("restart count", 16'h0003, 16'(n));
        check("exhausted", 16'h0001, 16'(restartsExhausted));
        // rearm, then unlimited attempts with the long wait
        @(posedge clk);
        motorRestart <= 1'b1;
        @(posedge clk);
        motorRestart <= 1'b0;
        i_host.wr(OFS_RESTART_BRAKE, 16'h0800);
        for (int f = 0; f < 4; f++) begin
            fault_pulse();
            req_count(35, n);
            check("long wait early", 16'h0000, 16'(n));
            req_count(10, n);
            check("long wait pulse", 16'h0001, 16'(n));
        end
        check("always retry", 16'h0000, 16'(restartsExhausted));
        conclude();
    end

    // whole sequence runs in under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        conclude();
    end
endmodule
`default_nettype wire
